// ### core/pt2_pkg.sv
// Purpose: Shared constants and types for the port 2 timing register bank
// Assumes: 16-bit host bus with byte offsets, one clock domain
// Notes: Offsets are byte addresses of 16-bit registers
package pt2_pkg;

  // Register byte offsets
  localparam logic [11:0] PT2_TX_LAT_OFF = 12'h662;
  localparam logic [11:0] PT2_ASYM_OFF = 12'h664;
  localparam logic [11:0] PT2_LINK_DLY_OFF = 12'h666;
  localparam logic [11:0] PT2_DLY_LO_OFF = 12'h668;
  localparam logic [11:0] PT2_DLY_HI_OFF = 12'h66a;
  localparam logic [11:0] PT2_SYNC_LO_OFF = 12'h66c;
  localparam logic [11:0] PT2_SYNC_HI_OFF = 12'h66e;
  localparam logic [11:0] PT2_PEER_LO_OFF = 12'h670;
  localparam logic [11:0] PT2_PEER_HI_OFF = 12'h672;
  localparam logic [11:0] PT2_BANK_LAST = 12'h673;
  localparam logic [11:0] PT2_RSV_FIRST = 12'h674;
  localparam logic [11:0] PT2_RSV_LAST = 12'h67f;
  localparam logic [11:0] PT2_TS_STATUS_OFF = 12'h68c;

  // Word indices inside the bank, in offset order
  localparam int PT2_NWORDS = 9;
  localparam logic [3:0] PT2_IDX_TX_LAT = 4'h0;
  localparam logic [3:0] PT2_IDX_ASYM = 4'h1;
  localparam logic [3:0] PT2_IDX_LINK_DLY = 4'h2;
  localparam logic [3:0] PT2_IDX_DLY_LO = 4'h3;
  localparam logic [3:0] PT2_IDX_DLY_HI = 4'h4;
  localparam logic [3:0] PT2_IDX_SYNC_LO = 4'h5;
  localparam logic [3:0] PT2_IDX_SYNC_HI = 4'h6;
  localparam logic [3:0] PT2_IDX_PEER_LO = 4'h7;
  localparam logic [3:0] PT2_IDX_PEER_HI = 4'h8;

  // Reset values
  localparam logic [15:0] PT2_TX_LAT_RST = 16'h002d;
  localparam logic [15:0] PT2_ZERO_RST = 16'h0000;
  localparam logic [1:0] PT2_FLAGS_RST = 2'h0;

  // Field positions
  localparam int PT2_SIGN_BIT = 15;
  localparam int PT2_SEC_LSB = 14;
  localparam int PT2_DLY_FLAG_BIT = 15;
  localparam int PT2_SYNC_FLAG_BIT = 14;
  localparam int PT2_CORR_FRAC_BITS = 16;

  typedef enum logic [2:0] {
    PT2_MSG_SYNC,
    PT2_MSG_DELAY_REQ,
    PT2_MSG_PDELAY_REQ,
    PT2_MSG_PDELAY_RESP,
    PT2_MSG_OTHER
  } pt2_msg_t;

  typedef enum logic [1:0] {
    PT2_TS_DELAY_REQ,
    PT2_TS_SYNC,
    PT2_TS_PEER_RESP
  } pt2_ts_kind_t;

  typedef struct packed {
    logic [PT2_NWORDS-1:0][15:0] word;
    logic [1:0] flags;
    logic [15:0] rdata;
    logic rvalid;
  } pt2_regs_t;

  typedef struct packed {
    logic valid;
    logic [63:0] field;
  } pt2_corr_state_t;

endpackage

// ### core/pt2_corr_if.sv
// Purpose: Carries the correction request and result between bank and adder
// Assumes: Same clock on both sides
// Notes: Correction field is in units of 2^-16 ns
`timescale 1ns/100ps
interface pt2_corr_if;
  import pt2_pkg::*;
  logic [15:0] asym;
  logic in_valid;
  pt2_msg_t msg;
  logic egress;
  logic [63:0] field_in;
  logic out_valid;
  logic [63:0] field_out;
  modport bank (output asym, in_valid, msg, egress, field_in, input out_valid, field_out);
  modport corr (input asym, in_valid, msg, egress, field_in, output out_valid, field_out);
endinterface

// ### core/pt2_corr_unit.sv
// Purpose: Applies the signed asymmetry value to a PTP correction field
// Assumes: One request per cycle at most, result one enabled cycle later
// Notes: Messages outside the two cases pass through unchanged
`timescale 1ns/100ps
module pt2_corr_unit
  import pt2_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Request and result
  pt2_corr_if.corr cif
);

  pt2_corr_state_t st_reg;
  pt2_corr_state_t st_next;
  logic [63:0] asym_ext;

  // Sign-magnitude to two's complement, scaled to the field's fraction
  function automatic logic [63:0] asym_to_field(input logic [15:0] a);
    logic [63:0] mag;
    mag = {33'h0, a[14:0], 16'h0};
    return a[PT2_SIGN_BIT] ? (64'h0 - mag) : mag;
  endfunction

  assign asym_ext = asym_to_field(cif.asym);

  // Next result
  always_comb begin
    st_next = st_reg;
    st_next.valid = cif.in_valid;
    if (cif.in_valid) begin
      st_next.field = cif.field_in;
      unique case (cif.msg)
        PT2_MSG_SYNC, PT2_MSG_PDELAY_RESP: begin
          if (!cif.egress) begin
            st_next.field = cif.field_in + asym_ext;
          end
        end
        PT2_MSG_DELAY_REQ, PT2_MSG_PDELAY_REQ: begin
          if (cif.egress) begin
            st_next.field = cif.field_in - asym_ext;
          end
        end
        default: begin
          st_next.field = cif.field_in;
        end
      endcase
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign cif.out_valid = st_reg.valid;
  assign cif.field_out = st_reg.field;

  corr_add_ing_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ce_i && cif.in_valid && !cif.egress && (cif.msg == PT2_MSG_SYNC || cif.msg == PT2_MSG_PDELAY_RESP)
    |=> cif.out_valid && cif.field_out == $past(cif.field_in) + $past(asym_ext))
    else $error("ingress correction not added");

  corr_sub_egr_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    ce_i && cif.in_valid && cif.egress && (cif.msg == PT2_MSG_DELAY_REQ || cif.msg == PT2_MSG_PDELAY_REQ)
    |=> cif.out_valid && cif.field_out == $past(cif.field_in) - $past(asym_ext))
    else $error("egress correction not subtracted");

  corr_neg_cov: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    ce_i && cif.in_valid && cif.asym[PT2_SIGN_BIT] && !cif.egress);

endmodule

// ### core/pt2_timing_regs.sv
// Purpose: Port 2 PTP timing register bank with egress timestamp capture
// Assumes: Host bus and timestamp sources run on clock_i
// Notes: Read data returns one enabled cycle after the read strobe
// How it works
// - Transmit latency register, 16 bits read-write, resets to 45 ns.
// - Asymmetry bit 15 is sign, bits 14:0 magnitude, both reset zero.
// - Ingress Sync and Pdelay_Resp get asymmetry added to correction field.
// - Egress Delay_Req and Pdelay_Req get asymmetry subtracted from correction field.
// - Link delay register, 16 bits read-write, resets to zero.
// - Delay request stamp low word holds nanoseconds 15:0.
// - Delay request stamp high word holds seconds 1:0 and nanoseconds 29:16.
// - Sync stamp uses the same low and high word layout.
// - Peer response stamp uses the same low and high word layout.
// - Sync stamp arrival sets write-one-to-clear status bit 14.
// - Delay or peer stamp arrival sets write-one-to-clear status bit 15.
`timescale 1ns/100ps
module pt2_timing_regs
  import pt2_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Host register port
  input wire logic [11:0] host_addr_i,
  input wire logic [15:0] host_wdata_i,
  input wire logic [1:0] host_be_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  output logic [15:0] host_rdata_o,
  output logic host_rvalid_o,
  // Egress timestamp capture
  input wire logic ts_valid_i,
  input wire pt2_ts_kind_t ts_kind_i,
  input wire logic [1:0] ts_seconds_i,
  input wire logic [29:0] ts_ns_i,
  // Correction field path
  input wire logic corr_valid_i,
  input wire pt2_msg_t corr_msg_i,
  input wire logic corr_egress_i,
  input wire logic [63:0] corr_field_i,
  output logic corr_valid_o,
  output logic [63:0] corr_field_o,
  // Settings and status toward the port logic
  output logic [15:0] tx_latency_o,
  output logic [15:0] link_delay_o,
  output logic [1:0] ts_flags_o
);

  pt2_regs_t r_reg;
  pt2_regs_t r_next;
  logic in_bank;
  logic in_rsv;
  logic hit_status;
  logic [11:0] bank_ofs;
  logic [3:0] idx;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  pt2_corr_if cif ();

  // Byte-lane merge of a host write into an existing word
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // High word of a stamp: seconds 1:0 above nanoseconds 29:16
  function automatic logic [15:0] stamp_high(input logic [1:0] sec, input logic [29:0] ns);
    return {sec, ns[29:16]};
  endfunction

  // Address decode; bit 0 is ignored since every register is a 16-bit word
  assign in_bank = host_addr_i >= PT2_TX_LAT_OFF && host_addr_i <= PT2_BANK_LAST;
  assign in_rsv = host_addr_i >= PT2_RSV_FIRST && host_addr_i <= PT2_RSV_LAST;
  assign hit_status = host_addr_i[11:1] == PT2_TS_STATUS_OFF[11:1];
  assign bank_ofs = host_addr_i - PT2_TX_LAT_OFF;
  assign idx = bank_ofs[4:1];

  // Status flag set and clear terms
  always_comb begin
    flag_set = 2'h0;
    if (ts_valid_i) begin
      flag_set[1] = ts_kind_i == PT2_TS_DELAY_REQ || ts_kind_i == PT2_TS_PEER_RESP;
      flag_set[0] = ts_kind_i == PT2_TS_SYNC;
    end
    flag_clr = 2'h0;
    if (host_wr_i && hit_status && host_be_i[1]) begin
      flag_clr = {host_wdata_i[PT2_DLY_FLAG_BIT], host_wdata_i[PT2_SYNC_FLAG_BIT]};
    end
  end

  // Next state: host writes first, then hardware captures so they win
  always_comb begin
    r_next = r_reg;
    r_next.rvalid = 1'b0;
    if (host_wr_i && in_bank) begin
      r_next.word[idx] = lane_merge(r_reg.word[idx], host_wdata_i, host_be_i);
    end
    if (ts_valid_i) begin
      unique case (ts_kind_i)
        PT2_TS_DELAY_REQ: begin
          r_next.word[PT2_IDX_DLY_LO] = ts_ns_i[15:0];
          r_next.word[PT2_IDX_DLY_HI] = stamp_high(ts_seconds_i, ts_ns_i);
        end
        PT2_TS_SYNC: begin
          r_next.word[PT2_IDX_SYNC_LO] = ts_ns_i[15:0];
          r_next.word[PT2_IDX_SYNC_HI] = stamp_high(ts_seconds_i, ts_ns_i);
        end
        PT2_TS_PEER_RESP: begin
          r_next.word[PT2_IDX_PEER_LO] = ts_ns_i[15:0];
          r_next.word[PT2_IDX_PEER_HI] = stamp_high(ts_seconds_i, ts_ns_i);
        end
        default: begin
          r_next.word = r_next.word;
        end
      endcase
    end
    // A new arrival beats a clear in the same cycle
    r_next.flags = (r_reg.flags & ~flag_clr) | flag_set;
    // Read answer: bank word, status image, or zero for anything unmapped
    if (host_rd_i) begin
      r_next.rvalid = 1'b1;
      if (in_bank) begin
        r_next.rdata = r_reg.word[idx];
      end else if (hit_status) begin
        r_next.rdata = {r_reg.flags, 14'h0};
      end else begin
        r_next.rdata = 16'h0000;
      end
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Constants only, so no logic sits in the asynchronous reset path
      r_reg <= '0;
      r_reg.word <= '{default: PT2_ZERO_RST};
      r_reg.word[PT2_IDX_TX_LAT] <= PT2_TX_LAT_RST;
      r_reg.flags <= PT2_FLAGS_RST;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state
  assign host_rdata_o = r_reg.rdata;
  assign host_rvalid_o = r_reg.rvalid;
  assign tx_latency_o = r_reg.word[PT2_IDX_TX_LAT];
  assign link_delay_o = r_reg.word[PT2_IDX_LINK_DLY];
  assign ts_flags_o = r_reg.flags;

  // Correction adder fed from the asymmetry register
  assign cif.asym = r_reg.word[PT2_IDX_ASYM];
  assign cif.in_valid = corr_valid_i;
  assign cif.msg = corr_msg_i;
  assign cif.egress = corr_egress_i;
  assign cif.field_in = corr_field_i;
  assign corr_valid_o = cif.out_valid;
  assign corr_field_o = cif.field_out;

  pt2_corr_unit u_corr (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .cif(cif)
  );

  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  tx_lat_write_a: assert property (ce_i && host_wr_i && host_addr_i == PT2_TX_LAT_OFF && host_be_i == 2'h3
    |=> tx_latency_o == $past(host_wdata_i)) else $error("tx latency write lost");
  asym_to_adder_a: assert property (ce_i && host_wr_i && host_addr_i == PT2_ASYM_OFF && host_be_i == 2'h3
    |=> cif.asym == $past(host_wdata_i)) else $error("asymmetry value not forwarded");
  link_dly_write_a: assert property (ce_i && host_wr_i && host_addr_i == PT2_LINK_DLY_OFF && host_be_i == 2'h3
    |=> link_delay_o == $past(host_wdata_i)) else $error("link delay write lost");
  dly_stamp_lo_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_DELAY_REQ
    |=> r_reg.word[PT2_IDX_DLY_LO] == $past(ts_ns_i[15:0])) else $error("delay stamp low wrong");
  dly_stamp_hi_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_DELAY_REQ
    |=> r_reg.word[PT2_IDX_DLY_HI] == {$past(ts_seconds_i), $past(ts_ns_i[29:16])}) else $error("delay stamp high wrong");
  sync_stamp_hi_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_SYNC
    |=> r_reg.word[PT2_IDX_SYNC_HI] == {$past(ts_seconds_i), $past(ts_ns_i[29:16])}) else $error("sync stamp wrong");
  peer_stamp_lo_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_PEER_RESP
    |=> r_reg.word[PT2_IDX_PEER_LO] == $past(ts_ns_i[15:0])) else $error("peer stamp wrong");
  sync_flag_set_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_SYNC
    |=> ts_flags_o[0] ##1 (ts_flags_o[0] || $past(ce_i && host_wr_i && hit_status))) else $error("sync flag not set");
  dly_flag_set_a: assert property (ce_i && ts_valid_i && ts_kind_i != PT2_TS_SYNC
    |=> ts_flags_o[1]) else $error("delay flag not set");
  rsv_read_zero_a: assert property (ce_i && host_rd_i && in_rsv
    |=> host_rvalid_o && host_rdata_o == 16'h0000) else $error("reserved read not zero");

  // Remaining stamp words
  sync_stamp_lo_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_SYNC
    |=> r_reg.word[PT2_IDX_SYNC_LO] == $past(ts_ns_i[15:0])) else $error("sync stamp low wrong");
  peer_stamp_hi_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_PEER_RESP
    |=> r_reg.word[PT2_IDX_PEER_HI] == {$past(ts_seconds_i), $past(ts_ns_i[29:16])})
    else $error("peer stamp high wrong");

  // Status flags: an arrival beats a clear, a clear alone drops the bit
  flag_set_wins_a: assert property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_SYNC
    && host_wr_i && hit_status |=> ts_flags_o[0]) else $error("sync flag lost to clear");
  sync_flag_clear_a: assert property (ce_i && host_wr_i && hit_status && host_be_i[1]
    && host_wdata_i[PT2_SYNC_FLAG_BIT] && !(ts_valid_i && ts_kind_i == PT2_TS_SYNC)
    |=> !ts_flags_o[0]) else $error("sync flag not cleared");
  dly_flag_clear_a: assert property (ce_i && host_wr_i && hit_status && host_be_i[1]
    && host_wdata_i[PT2_DLY_FLAG_BIT] && !(ts_valid_i && ts_kind_i != PT2_TS_SYNC)
    |=> !ts_flags_o[1]) else $error("delay flag not cleared");
  status_read_a: assert property (ce_i && host_rd_i && hit_status
    |=> host_rvalid_o && host_rdata_o == {$past(ts_flags_o), 14'h0}) else $error("status read wrong");

  // Read path, reserved range and the enable
  tx_lat_read_a: assert property (ce_i && host_rd_i && host_addr_i[11:1] == PT2_TX_LAT_OFF[11:1]
    |=> host_rvalid_o && host_rdata_o == $past(tx_latency_o)) else $error("tx latency read wrong");
  rsv_write_ign_a: assert property (ce_i && host_wr_i && in_rsv && !ts_valid_i
    |=> $stable(r_reg.word)) else $error("reserved write changed the bank");
  enable_freeze_a: assert property (!ce_i |=> $stable(r_reg)) else $error("state moved with enable low");

  sync_capture_cov: cover property (ce_i && ts_valid_i && ts_kind_i == PT2_TS_SYNC ##1 ce_i && host_rd_i && hit_status);
  flag_clear_cov: cover property (ts_flags_o[1] ##1 ce_i && host_wr_i && hit_status ##1 !ts_flags_o[1]);
  rsv_write_cov: cover property (ce_i && host_wr_i && in_rsv);
  stamp_clear_cov: cover property (ce_i && ts_valid_i && host_wr_i && hit_status);

endmodule

// ### tb/pt2_port_model.sv
// Purpose: Port-side model that issues egress stamps and correction requests
// Assumes: Requests change just after the rising edge, one cycle each
// Notes: The ns and field lines are inverted once valid drops so stale values never look good
`timescale 1ns/100ps
module pt2_port_model
  import pt2_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Toward the bank
  output logic ts_valid_o,
  output pt2_ts_kind_t ts_kind_o,
  output logic [1:0] ts_seconds_o,
  output logic [29:0] ts_ns_o,
  output logic corr_valid_o,
  output pt2_msg_t corr_msg_o,
  output logic corr_egress_o,
  output logic [63:0] corr_field_o
);
  // Idle state at time zero
  initial begin
    ts_valid_o = 1'b0;
    ts_kind_o = PT2_TS_SYNC;
    ts_seconds_o = 2'h0;
    ts_ns_o = 30'h0;
    corr_valid_o = 1'b0;
    corr_msg_o = PT2_MSG_OTHER;
    corr_egress_o = 1'b0;
    corr_field_o = 64'h0;
  end

  // One egress stamp, a single-cycle pulse
  task automatic stamp(input pt2_ts_kind_t k, input logic [1:0] s, input logic [29:0] n);
    @(posedge clock_i);
    #1;
    ts_kind_o = k;
    ts_seconds_o = s;
    ts_ns_o = n;
    ts_valid_o = 1'b1;
    @(posedge clock_i);
    #1;
    ts_valid_o = 1'b0;
    ts_ns_o = ~ts_ns_o;
  endtask

  // One correction request, a single-cycle pulse
  task automatic corr(input pt2_msg_t m, input logic e, input logic [63:0] f);
    @(posedge clock_i);
    #1;
    corr_msg_o = m;
    corr_egress_o = e;
    corr_field_o = f;
    corr_valid_o = 1'b1;
    @(posedge clock_i);
    #1;
    corr_valid_o = 1'b0;
    corr_field_o = ~corr_field_o;
  endtask
endmodule

// ### tb/test_pt2_timing_regs.sv
// Purpose: Self-checking bench for the port 2 timing register bank
// Assumes: Host strobes are one-cycle pulses, read answer one cycle later
// Notes: Expected values come from the bench's own arithmetic
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_pt2_timing_regs
  import pt2_pkg::*;
;
  logic clock_i, arst_n_i, ce_i, host_wr_i, host_rd_i, host_rvalid_o;
  logic [11:0] host_addr_i;
  logic [15:0] host_wdata_i, host_rdata_o, tx_latency_o, link_delay_o;
  logic [1:0] host_be_i, ts_flags_o, ts_seconds;
  logic ts_valid, corr_valid, corr_egress, corr_valid_o;
  pt2_ts_kind_t ts_kind;
  pt2_msg_t corr_msg;
  logic [29:0] ts_ns;
  logic [63:0] corr_field, corr_field_o;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  pt2_msg_t cm [5] = '{PT2_MSG_SYNC, PT2_MSG_PDELAY_RESP, PT2_MSG_DELAY_REQ, PT2_MSG_PDELAY_REQ, PT2_MSG_SYNC};
  logic cdir [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  int csg [5] = '{1, 1, -1, -1, 0};
  logic [15:0] asym [2] = '{16'h0005, 16'h8003};

  pt2_timing_regs DUT (.clock_i, .arst_n_i, .ce_i, .host_addr_i, .host_wdata_i, .host_be_i, .host_wr_i,
    .host_rd_i, .host_rdata_o, .host_rvalid_o, .ts_valid_i(ts_valid), .ts_kind_i(ts_kind),
    .ts_seconds_i(ts_seconds), .ts_ns_i(ts_ns), .corr_valid_i(corr_valid), .corr_msg_i(corr_msg),
    .corr_egress_i(corr_egress), .corr_field_i(corr_field), .corr_valid_o, .corr_field_o,
    .tx_latency_o, .link_delay_o, .ts_flags_o);
  pt2_port_model PM (.clock_i, .ts_valid_o(ts_valid), .ts_kind_o(ts_kind), .ts_seconds_o(ts_seconds),
    .ts_ns_o(ts_ns), .corr_valid_o(corr_valid), .corr_msg_o(corr_msg), .corr_egress_o(corr_egress),
    .corr_field_o(corr_field));

  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Host write: strobe held for exactly one taking edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge clock_i);
    #1;
    host_addr_i = a;
    host_wdata_i = d;
    host_be_i = b;
    host_wr_i = 1'b1;
    @(posedge clock_i);
    #1;
    host_wr_i = 1'b0;
  endtask

  // Host read: answer is a one-cycle pulse, so it is looked at right after it lands
  task automatic rd(input logic [11:0] a, input logic [15:0] e, input string nm);
    @(posedge clock_i);
    #1;
    host_addr_i = a;
    host_rd_i = 1'b1;
    @(posedge clock_i);
    #1;
    host_rd_i = 1'b0;
    `CHK({nm, " valid"}, 1'b1, host_rvalid_o)
    `CHK(nm, e, host_rdata_o)
  endtask

  // Sign-magnitude asymmetry in ns, shifted into the 2^-16 ns field
  function automatic logic [63:0] exp_corr(input logic [15:0] a, input logic [63:0] f, input int s);
    logic [63:0] d;
    d = {33'h0, a[14:0], 16'h0};
    if (a[15]) d = -d;
    return (s > 0) ? f + d : ((s < 0) ? f - d : f);
  endfunction

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // Hang guard, far above the roughly 150 cycles the tests need
  initial begin
    forever begin
      @(posedge clock_i);
      cycles++;
      if (cycles == 3000) begin
        n_mismatch++;
        close_out();
      end
    end
  end

  initial begin
    arst_n_i = 1'b0;
    ce_i = 1'b1;
    host_wr_i = 1'b0;
    host_rd_i = 1'b0;
    host_addr_i = 12'h000;
    host_wdata_i = 16'h0000;
    host_be_i = 2'h3;
    repeat (12) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    // Reset values of the whole bank
    for (int i = 0; i < 9; i++) begin
      rd(PT2_TX_LAT_OFF + 12'(2 * i), (i == 0) ? 16'h002d : 16'h0000, "reset");
    end
    `CHK("tx_latency_o", 16'h002d, tx_latency_o)
    // Every word is read-write, each with a distinct pattern
    for (int i = 0; i < 9; i++) begin
      wr(PT2_TX_LAT_OFF + 12'(2 * i), 16'ha5c0 ^ 16'(i), 2'h3);
      rd(PT2_TX_LAT_OFF + 12'(2 * i), 16'ha5c0 ^ 16'(i), "rw");
    end
    `CHK("tx_latency_o", 16'ha5c0, tx_latency_o)
    wr(PT2_LINK_DLY_OFF, 16'h1234, 2'h1);
    `CHK("link_delay_o", 16'ha534, link_delay_o)
    // Enable low freezes the bank: writes and stamps are dropped
    ce_i = 1'b0;
    wr(PT2_TX_LAT_OFF, 16'h1111, 2'h3);
    PM.stamp(PT2_TS_SYNC, 2'h1, 30'h0);
    `CHK("frozen latency", 16'ha5c0, tx_latency_o)
    `CHK("frozen flags", 2'h0, ts_flags_o)
    ce_i = 1'b1;
    // Reserved range ignores writes and reads zero
    wr(12'h674, 16'hffff, 2'h3);
    wr(12'h67e, 16'hffff, 2'h3);
    rd(12'h674, 16'h0000, "rsv lo");
    rd(12'h67e, 16'h0000, "rsv hi");
    // Each stamp kind lands in its own pair; Sync raises bit 14, delay and peer share bit 15
    for (int k = 0; k < 3; k++) begin
      PM.stamp(pt2_ts_kind_t'(k), 2'(k + 1), 30'h2abc1234 + 30'(k));
      rd(PT2_DLY_LO_OFF + 12'(4 * k), 16'h1234 + 16'(k), "stamp lo");
      rd(PT2_DLY_HI_OFF + 12'(4 * k), {2'(k + 1), 14'h2abc}, "stamp hi");
      `CHK("flags", (k == 1) ? 2'h1 : 2'h2, ts_flags_o)
      rd(PT2_TS_STATUS_OFF, (k == 1) ? 16'h4000 : 16'h8000, "status");
      wr(PT2_TS_STATUS_OFF, (k == 1) ? 16'h8000 : 16'h4000, 2'h3);
      `CHK("flags kept", (k == 1) ? 2'h1 : 2'h2, ts_flags_o)
      wr(PT2_TS_STATUS_OFF, 16'hc000, 2'h3);
      `CHK("flags clear", 2'h0, ts_flags_o)
    end
    // A stamp and a clear taken at one edge: the new arrival wins
    fork
      PM.stamp(PT2_TS_SYNC, 2'h0, 30'h0);
      wr(PT2_TS_STATUS_OFF, 16'hc000, 2'h3);
    join
    `CHK("set beats clear", 2'h1, ts_flags_o)
    wr(PT2_TS_STATUS_OFF, 16'h4000, 2'h3);
    `CHK("sync flag clear", 2'h0, ts_flags_o)
    // Correction: add on ingress, subtract on egress, others untouched
    for (int a = 0; a < 2; a++) begin
      wr(PT2_ASYM_OFF, asym[a], 2'h3);
      for (int c = 0; c < 5; c++) begin
        PM.corr(cm[c], cdir[c], 64'h0000_0123_4567_89ab);
        `CHK("corr valid", 1'b1, corr_valid_o)
        `CHK("corr field", exp_corr(asym[a], 64'h0000_0123_4567_89ab, csg[c]), corr_field_o)
      end
    end
    close_out();
  end
endmodule
